// [rtl/mfb_defs.svh]
// Purpose: Constants of the math function block: offsets, fields, resets, fixed point.
// Assumes: Byte addresses on an 8-bit Wishbone address, 32-bit data.
// Notes: Included by bare name.
// Contract
// - Four inputs, each with own settings
// - Normalise input to percent of span
// - Weight each input by signed scaler
// - Codes 0-5 compare operands
// - Codes 6-8 give OR, AND, XOR
// - Codes 9-14 give arithmetic, min, max
// - Functions chained over inputs two to four
// - Self-sourced input picks function or output
// - Unused input skips its function
// - Logic truth at one half or above
// - Compare and logic yield zero or one
// - Erroneous input becomes zero
// - Divide by zero yields zero
// - Negative difference clamps to zero
// - Map result onto output min, max
`ifndef MFB_DEFS_SVH
`define MFB_DEFS_SVH

`define MFB_ADR_OPS 8'h00
`define MFB_ADR_OMIN 8'h04
`define MFB_ADR_OMAX 8'h08
`define MFB_ADR_STAT 8'h0C
`define MFB_ADR_RESULT 8'h50
`define MFB_ADR_FRES1 8'h54
`define MFB_ADR_FRES2 8'h58
`define MFB_ADR_FRES3 8'h5C
`define MFB_ADR_FPCT 8'h60
`define MFB_GRP_FIRST 4'h1
`define MFB_GRP_LAST 4'h4
`define MFB_WRD_CFG 2'h0
`define MFB_WRD_MIN 2'h1
`define MFB_WRD_MAX 2'h2
`define MFB_WRD_SCL 2'h3

`define MFB_CFG_SRC_LSB 0
`define MFB_CFG_FSEL_LSB 4
`define MFB_STAT_VALID_BIT 8

`define MFB_OPS_RST 12'h999
`define MFB_OMIN_RST 32'h0000_0000
`define MFB_OMAX_RST 32'h0000_0064
`define MFB_CFG_RST 6'h01
`define MFB_IN_MAX_RST 32'h0000_7FFF
`define MFB_SCL_RST 16'h4000
`define MFB_SCL_ONE 16'h4000
`define MFB_SCL_FRAC 14
`define MFB_FRAC 16

`endif

// [rtl/mfb_pkg.sv]
// Purpose: Types of the math function block.
// Assumes: Nothing.
// Notes: Used only by scoped names.
package mfb_pkg;
	typedef enum logic [3:0] {
		MFB_OP_EQ = 4'h0, MFB_OP_NE = 4'h1, MFB_OP_GT = 4'h2, MFB_OP_GE = 4'h3,
		MFB_OP_LT = 4'h4, MFB_OP_LE = 4'h5, MFB_OP_OR = 4'h6, MFB_OP_AND = 4'h7,
		MFB_OP_XOR = 4'h8, MFB_OP_ADD = 4'h9, MFB_OP_SUB = 4'hA, MFB_OP_MUL = 4'hB,
		MFB_OP_DIV = 4'hC, MFB_OP_MIN = 4'hD, MFB_OP_MAX = 4'hE
	} mfb_op_t;
	typedef enum logic [1:0] {
		MFB_SRC_UNUSED = 2'h0, MFB_SRC_EXT = 2'h1, MFB_SRC_SELF = 2'h2
	} mfb_src_t;
	typedef enum logic [2:0] {
		MFB_S_NORM = 3'b001, MFB_S_FUNC = 3'b010, MFB_S_MAP = 3'b100
	} mfb_state_t;
endpackage

// [rtl/mfb_alu.sv]
// Purpose: One math function: compare, logic or arithmetic on two percentages.
// Assumes: Operands in signed fixed point, full scale at one.
// Notes: Purely combinational.
`timescale 1ns/1ns
`include "mfb_defs.svh"
module mfb_alu #(
	parameter int W = 24
) (
	input wire mfb_pkg::mfb_op_t op_i,
	input wire logic signed [W-1:0] a_i,
	input wire logic signed [W-1:0] b_i,
	output logic signed [W-1:0] res_o
);
	localparam logic signed [W-1:0] ONE = W'(1) << `MFB_FRAC;
	localparam logic signed [W-1:0] HALF = ONE >>> 1;
	localparam logic signed [2*W-1:0] ONE_X = {{W{1'b0}}, ONE};

	function automatic logic signed [W-1:0] sat(input logic signed [2*W-1:0] v);
		if (v > ONE_X)
			return ONE;
		if (v < -ONE_X)
			return -ONE;
		return v[W-1:0];
	endfunction

	logic signed [2*W-1:0] ax;
	logic signed [2*W-1:0] bx;
	logic signed [2*W-1:0] prod;
	logic signed [2*W-1:0] quo;
	logic ta;
	logic tb;

	always_comb begin
		ax = {{W{a_i[W-1]}}, a_i};
		bx = {{W{b_i[W-1]}}, b_i};
		ta = (a_i >= HALF);
		tb = (b_i >= HALF);
		prod = (ax * bx) >>> `MFB_FRAC;
		quo = (b_i == '0) ? '0 : (ax <<< `MFB_FRAC) / bx;
		res_o = '0;
		case (op_i)
			mfb_pkg::MFB_OP_EQ: res_o = (a_i == b_i) ? ONE : '0;
			mfb_pkg::MFB_OP_NE: res_o = (a_i != b_i) ? ONE : '0;
			mfb_pkg::MFB_OP_GT: res_o = (a_i > b_i) ? ONE : '0;
			mfb_pkg::MFB_OP_GE: res_o = (a_i >= b_i) ? ONE : '0;
			mfb_pkg::MFB_OP_LT: res_o = (a_i < b_i) ? ONE : '0;
			mfb_pkg::MFB_OP_LE: res_o = (a_i <= b_i) ? ONE : '0;
			mfb_pkg::MFB_OP_OR: res_o = (ta || tb) ? ONE : '0;
			mfb_pkg::MFB_OP_AND: res_o = (ta && tb) ? ONE : '0;
			mfb_pkg::MFB_OP_XOR: res_o = (ta != tb) ? ONE : '0;
			mfb_pkg::MFB_OP_ADD: res_o = sat(ax + bx);
			mfb_pkg::MFB_OP_SUB: res_o = (ax < bx) ? '0 : sat(ax - bx);
			mfb_pkg::MFB_OP_MUL: res_o = sat(prod);
			mfb_pkg::MFB_OP_DIV: res_o = sat(quo);
			mfb_pkg::MFB_OP_MIN: res_o = (a_i < b_i) ? a_i : b_i;
			mfb_pkg::MFB_OP_MAX: res_o = (a_i > b_i) ? a_i : b_i;
			default: res_o = '0;
		endcase
	end
endmodule

// [rtl/mfb_math_top.sv]
// Purpose: Math function block with four inputs, three chained functions, output mapping.
// Assumes: Inputs come from logic on clk_i; software sets up over classic Wishbone.
// Notes: One pass takes eight cycles: four normalise, three functions, one map.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "mfb_defs.svh"
module mfb_math_top #(
	parameter int DW = 16,
	parameter int W = 24
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [4*DW-1:0] in_data_i,
	input wire logic [3:0] in_err_i,
	output logic [31:0] out_data_o,
	output logic [31:0] out_min_o,
	output logic [31:0] out_max_o,
	output logic out_valid_o
);
	localparam logic signed [W-1:0] ONE = W'(1) << `MFB_FRAC;
	localparam int NW = DW + `MFB_FRAC + 2;

	typedef struct packed {
		mfb_pkg::mfb_state_t st;
		logic [1:0] idx;
		logic [11:0] ops;
		logic [31:0] omin;
		logic [31:0] omax;
		logic [3:0][5:0] cfg;
		logic [3:0][DW-1:0] imin;
		logic [3:0][DW-1:0] imax;
		logic [3:0][15:0] scl;
		logic [3:0][W-1:0] wpct;
		logic [2:0][W-1:0] fres;
		logic [W-1:0] fpct;
		logic [3:0] err;
		logic [31:0] out;
		logic valid;
		logic ack;
		logic [31:0] rdat;
	} mfb_regs_t;

	mfb_regs_t r_reg;
	mfb_regs_t r_next;

	function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] v;
		v = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b])
				v[b*8 +: 8] = nw[b*8 +: 8];
		end
		return v;
	endfunction

	function automatic logic signed [W-1:0] clamp_pct(input logic signed [W-1:0] p);
		if (p < 0)
			return '0;
		if (p > ONE)
			return ONE;
		return p;
	endfunction

	// percent of configured span, clamp outside limits, fixed point
	function automatic logic signed [W-1:0] norm_pct(input logic signed [DW-1:0] x, input logic signed [DW-1:0] mn,
			input logic signed [DW-1:0] mx);
		logic signed [NW-1:0] num;
		logic signed [NW-1:0] den;
		logic signed [NW-1:0] q;
		num = (NW'(x) - NW'(mn)) <<< `MFB_FRAC;
		den = NW'(mx) - NW'(mn);
		if (x <= mn)
			q = '0;
		else if (x >= mx)
			q = NW'(ONE);
		else
			q = num / den;
		return q[W-1:0];
	endfunction

	// weight within minus one to one
	function automatic logic signed [W-1:0] weight(input logic signed [W-1:0] p, input logic signed [15:0] sc);
		logic signed [15:0] s;
		logic signed [W+15:0] pr;
		s = sc;
		if (sc > $signed(`MFB_SCL_ONE))
			s = `MFB_SCL_ONE;
		else if (sc < -$signed(`MFB_SCL_ONE))
			s = -$signed(`MFB_SCL_ONE);
		pr = p * s;
		pr = pr >>> `MFB_SCL_FRAC;
		return pr[W-1:0];
	endfunction

	logic signed [W-1:0] fa;
	logic signed [W-1:0] fb;
	logic signed [W-1:0] alu_res;
	logic skip;
	mfb_pkg::mfb_op_t fop;

	assign fa = (r_reg.idx == 2'h0) ? $signed(r_reg.wpct[0]) : $signed(r_reg.fres[r_reg.idx - 2'h1]);
	assign fb = $signed(r_reg.wpct[r_reg.idx + 2'h1]);
	assign fop = mfb_pkg::mfb_op_t'(r_reg.ops[{r_reg.idx, 2'b00} +: 4]);
	assign skip = (r_reg.cfg[r_reg.idx + 2'h1][1:0] == mfb_pkg::MFB_SRC_UNUSED);

	mfb_alu #(.W(W)) u_alu (
		.op_i(fop),
		.a_i(fa),
		.b_i(fb),
		.res_o(alu_res)
	);

	always_comb begin
		logic req;
		logic [3:0] grp;
		logic [1:0] gi;
		logic [1:0] wrd;
		logic [31:0] rd;
		logic [31:0] wv;
		logic signed [W-1:0] pin;
		logic signed [W-1:0] pm;
		logic signed [32:0] span;
		logic signed [33+W-1:0] mp;
		logic [1:0] src;
		logic [1:0] fsel;
		req = wb_cyc_i && wb_stb_i && !r_reg.ack;
		grp = wb_adr_i[7:4];
		gi = 2'(grp - 4'h1);
		wrd = wb_adr_i[3:2];
		rd = 32'h0000_0000;
		pin = '0;
		pm = '0;
		span = '0;
		mp = '0;
		src = r_reg.cfg[r_reg.idx][1:0];
		fsel = r_reg.cfg[r_reg.idx][5:4];
		r_next = r_reg;
		r_next.ack = req;
		if (grp >= `MFB_GRP_FIRST && grp <= `MFB_GRP_LAST) begin
			case (wrd)
				`MFB_WRD_CFG: rd = {26'h0, r_reg.cfg[gi]};
				`MFB_WRD_MIN: rd = 32'($signed(r_reg.imin[gi]));
				`MFB_WRD_MAX: rd = 32'($signed(r_reg.imax[gi]));
				default: rd = {16'h0, r_reg.scl[gi]};
			endcase
		end else begin
			case (wb_adr_i)
				`MFB_ADR_OPS: rd = {20'h0, r_reg.ops};
				`MFB_ADR_OMIN: rd = r_reg.omin;
				`MFB_ADR_OMAX: rd = r_reg.omax;
				`MFB_ADR_STAT: rd = {23'h0, r_reg.valid, 4'h0, r_reg.err};
				`MFB_ADR_RESULT: rd = r_reg.out;
				`MFB_ADR_FRES1: rd = 32'($signed(r_reg.fres[0]));
				`MFB_ADR_FRES2: rd = 32'($signed(r_reg.fres[1]));
				`MFB_ADR_FRES3: rd = 32'($signed(r_reg.fres[2]));
				`MFB_ADR_FPCT: rd = 32'($signed(r_reg.fpct));
				default: rd = 32'h0000_0000;
			endcase
		end
		wv = apply_sel(rd, wb_dat_i, wb_sel_i);
		if (req && !wb_we_i)
			r_next.rdat = rd;
		if (req && wb_we_i) begin
			if (grp >= `MFB_GRP_FIRST && grp <= `MFB_GRP_LAST) begin
				case (wrd)
					`MFB_WRD_CFG: r_next.cfg[gi] = wv[5:0];
					`MFB_WRD_MIN: r_next.imin[gi] = wv[DW-1:0];
					`MFB_WRD_MAX: r_next.imax[gi] = wv[DW-1:0];
					default: r_next.scl[gi] = wv[15:0];
				endcase
			end else begin
				case (wb_adr_i)
					`MFB_ADR_OPS: r_next.ops = wv[11:0];
					`MFB_ADR_OMIN: r_next.omin = wv;
					`MFB_ADR_OMAX: r_next.omax = wv;
					default: r_next.ops = r_reg.ops;
				endcase
			end
		end
		case (r_reg.st)
			mfb_pkg::MFB_S_NORM: begin
				case (src)
					mfb_pkg::MFB_SRC_EXT: begin
						if (in_err_i[r_reg.idx])
							pin = '0;
						else
							pin = norm_pct($signed(in_data_i[r_reg.idx*DW +: DW]), $signed(r_reg.imin[r_reg.idx]),
								$signed(r_reg.imax[r_reg.idx]));
					end
					mfb_pkg::MFB_SRC_SELF: begin
						if (fsel == 2'h0)
							pin = clamp_pct($signed(r_reg.fpct));
						else
							pin = clamp_pct($signed(r_reg.fres[fsel - 2'h1]));
					end
					default: pin = '0;
				endcase
				r_next.wpct[r_reg.idx] = weight(pin, $signed(r_reg.scl[r_reg.idx]));
				r_next.err[r_reg.idx] = in_err_i[r_reg.idx] && (src == mfb_pkg::MFB_SRC_EXT);
				r_next.idx = r_reg.idx + 2'h1;
				if (r_reg.idx == 2'h3)
					r_next.st = mfb_pkg::MFB_S_FUNC;
			end
			mfb_pkg::MFB_S_FUNC: begin
				r_next.fres[r_reg.idx] = skip ? fa : alu_res;
				r_next.idx = r_reg.idx + 2'h1;
				if (r_reg.idx == 2'h2) begin
					r_next.idx = 2'h0;
					r_next.st = mfb_pkg::MFB_S_MAP;
				end
			end
			mfb_pkg::MFB_S_MAP: begin
				// linear map onto output range, saturated percent
				pm = clamp_pct($signed(r_reg.fres[2]));
				span = {r_reg.omax[31], r_reg.omax} - {r_reg.omin[31], r_reg.omin};
				mp = span * pm;
				r_next.fpct = r_reg.fres[2];
				r_next.out = r_reg.omin + mp[`MFB_FRAC +: 32];
				r_next.valid = 1'b1;
				r_next.st = mfb_pkg::MFB_S_NORM;
			end
			default: begin
				r_next.idx = 2'h0;
				r_next.st = mfb_pkg::MFB_S_NORM;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg <= '0;
			r_reg.st <= mfb_pkg::MFB_S_NORM;
			r_reg.ops <= `MFB_OPS_RST;
			r_reg.omin <= `MFB_OMIN_RST;
			r_reg.omax <= `MFB_OMAX_RST;
			r_reg.cfg <= {4{`MFB_CFG_RST}};
			r_reg.imax <= {4{DW'(`MFB_IN_MAX_RST)}};
			r_reg.scl <= {4{`MFB_SCL_RST}};
		end else begin
			r_reg <= r_next;
		end
	end

	assign wb_dat_o = r_reg.rdat;
	assign wb_ack_o = r_reg.ack;
	assign out_data_o = r_reg.out;
	assign out_min_o = r_reg.omin;
	assign out_max_o = r_reg.omax;
	assign out_valid_o = r_reg.valid;

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("request not acknowledged next cycle");
	a_bool_result: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_reg.st == mfb_pkg::MFB_S_FUNC && fop <= mfb_pkg::MFB_OP_XOR) |-> (alu_res == '0 || alu_res == ONE))
		else $error("logic result not zero or one");
	a_div_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_reg.st == mfb_pkg::MFB_S_FUNC && fop == mfb_pkg::MFB_OP_DIV && fb == '0) |-> alu_res == '0)
		else $error("division by zero not zero");
	a_sub_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_reg.st == mfb_pkg::MFB_S_FUNC && fop == mfb_pkg::MFB_OP_SUB && fa < fb) |-> alu_res == '0)
		else $error("negative difference not clamped");
	a_arith_sat: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_reg.st == mfb_pkg::MFB_S_FUNC) |-> (alu_res <= ONE && alu_res >= -ONE))
		else $error("function result beyond full scale");
	a_err_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_reg.st == mfb_pkg::MFB_S_NORM && src_ext_err()) |=> r_reg.wpct[$past(r_reg.idx)] == '0)
		else $error("erroneous input not zero");
	a_skip_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_reg.st == mfb_pkg::MFB_S_FUNC && skip) |=> $signed(r_reg.fres[$past(r_reg.idx)]) == $past(fa))
		else $error("skipped function did not pass result");
	a_pass_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_reg.st == mfb_pkg::MFB_S_MAP) |=> r_reg.st == mfb_pkg::MFB_S_NORM ##8 r_reg.st == mfb_pkg::MFB_S_NORM)
		else $error("pass not eight cycles");
	a_map_bounds: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_reg.st == mfb_pkg::MFB_S_MAP && $signed(r_reg.omin) <= $signed(r_reg.omax)) |=>
		($signed(out_data_o) >= $signed($past(r_reg.omin)) && $signed(out_data_o) <= $signed($past(r_reg.omax))))
		else $error("output outside output range");

	function automatic logic src_ext_err();
		return in_err_i[r_reg.idx] && (r_reg.cfg[r_reg.idx][1:0] == mfb_pkg::MFB_SRC_EXT);
	endfunction
endmodule

// [testbench/mfb_src_model.sv]
// Purpose: Model of the function blocks that feed the math block inputs.
// Assumes: Same clock as the math block; values set by the bench.
// Notes: Holds each value and error flag steady until the bench changes it.
`timescale 1ns/1ns
module mfb_src_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [63:0] val_i,
	input wire logic [3:0] err_i,
	output logic [63:0] in_data_o,
	output logic [3:0] in_err_o
);
	// Registered like any block output on the system clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_data_o <= 64'h0;
			in_err_o <= 4'h0;
		end else begin
			in_data_o <= val_i;
			in_err_o <= err_i;
		end
	end
endmodule

// [testbench/mfb_tb.sv]
// Purpose: Self-checking bench of the math function block.
// Assumes: Percent 100% is 0x10000; one pass takes eight cycles.
// Notes: Inputs use min 0, max 0x100, so raw 0x80 is 50%.
`timescale 1ns/1ns
`include "mfb_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [63:0] in_val = 64'h0;
	logic [3:0] in_errs = 4'h0;
	logic [31:0] wb_dat_o, out_data_o, out_min_o, out_max_o;
	logic wb_ack_o, out_valid_o;
	logic [63:0] in_data;
	logic [3:0] in_err;
	int err_count = 0;
	int compares = 0;
	always #5 clk_i = ~clk_i;
	mfb_src_model i_mfb_src_model (.clk_i(clk_i), .rst_i(rst_i), .val_i(in_val), .err_i(in_errs),
		.in_data_o(in_data), .in_err_o(in_err));
	mfb_math_top i_mfb_math_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .in_data_i(in_data), .in_err_i(in_err), .out_data_o(out_data_o),
		.out_min_o(out_min_o), .out_max_o(out_max_o), .out_valid_o(out_valid_o));
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= sel;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_sel_i <= 4'h0;
	endtask
	task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] q;
		wb_xfer(1'b1, adr, dat, 4'hF, q);
	endtask
	task automatic chk_rd(input string nm, input logic [7:0] adr, input logic [31:0] ex);
		logic [31:0] q;
		wb_xfer(1'b0, adr, 32'h0, 4'hF, q);
		`CHK(nm, ex, q)
	endtask
	task automatic set_in(input logic [3:0] k, input logic [31:0] cfg, input logic [31:0] scl);
		wb_wr({k, 4'h0}, cfg);
		wb_wr({k, 4'h4}, 32'h0);
		wb_wr({k, 4'h8}, 32'h0000_0100);
		wb_wr({k, 4'hC}, scl);
	endtask
	task automatic set_vals(input logic [63:0] v, input logic [3:0] e);
		@(posedge clk_i);
		in_val <= v;
		in_errs <= e;
		repeat (26) @(posedge clk_i);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		`CHK("valid", 1'b0, out_valid_o) // No output yet
		`CHK("omax", 32'h0000_0064, out_max_o) // Output limit default
		chk_rd("ops", `MFB_ADR_OPS, 32'h0000_0999); // Default add
		chk_rd("cfg1", 8'h10, 32'h0000_0001); // External source
		chk_rd("max1", 8'h18, 32'h0000_7FFF); // Span default
		chk_rd("scl1", 8'h1C, 32'h0000_4000); // Weight one
		wb_wr(8'h70, 32'hFFFF_FFFF);
		chk_rd("unmapped", 8'h70, 32'h0); // Outside map
		wb_xfer(1'b1, `MFB_ADR_OMAX, 32'hFFFF_FF32, 4'h1, q);
		`CHK("lanes", 32'h0000_0032, out_max_o) // Only low lane written
		wb_wr(`MFB_ADR_OMAX, 32'h0000_0064);
	endtask
	task automatic t_ops();
		logic [31:0] ex [15] = '{32'h0, 32'h10000, 32'h10000, 32'h10000, 32'h0, 32'h0, 32'h10000, 32'h0,
			32'h10000, 32'hC000, 32'h4000, 32'h2000, 32'h10000, 32'h4000, 32'h8000};
		set_in(4'h1, 32'h1, 32'h4000);
		set_in(4'h2, 32'h1, 32'h4000);
		set_in(4'h3, 32'h0, 32'h4000);
		set_in(4'h4, 32'h0, 32'h4000);
		set_vals(64'h0000_0000_0040_0080, 4'h0);
		for (int i = 0; i < 15; i++) begin
			wb_wr(`MFB_ADR_OPS, {24'h0, 4'h9, i[3:0]});
			repeat (26) @(posedge clk_i);
			chk_rd("fres1", `MFB_ADR_FRES1, ex[i]); // Every code
			chk_rd("final", `MFB_ADR_FPCT, ex[i]); // Skipped functions
			`CHK("out", (32'h0000_0064 * ex[i]) >> 16, out_data_o) // Linear map
		end
		`CHK("valid", 1'b1, out_valid_o) // Output present
	endtask
	task automatic t_edges();
		logic [67:0] tc [6] = '{{4'h0, 16'h80, 16'h80, 32'h10000}, {4'hA, 16'h40, 16'h80, 32'h0},
			{4'hC, 16'h80, 16'h0, 32'h0}, {4'h7, 16'h80, 16'h7F, 32'h0},
			{4'h7, 16'h80, 16'h80, 32'h10000}, {4'h9, 16'h80, 16'hC0, 32'h10000}};
		for (int i = 0; i < 6; i++) begin
			wb_wr(`MFB_ADR_OPS, {24'h0, 4'h9, tc[i][67:64]});
			set_vals({32'h0, tc[i][47:32], tc[i][63:48]}, 4'h0);
			chk_rd("edge", `MFB_ADR_FRES1, tc[i][31:0]); // Boundaries
		end
	endtask
	task automatic t_chain();
		set_in(4'h3, 32'h1, 32'h4000);
		set_in(4'h4, 32'h1, 32'h4000);
		wb_wr(`MFB_ADR_OPS, 32'h0000_0BA9);
		wb_wr(`MFB_ADR_OMIN, 32'h0000_000A);
		wb_wr(`MFB_ADR_OMAX, 32'h0000_006E);
		// Operands chosen to stay inside full scale
		set_vals(64'h0080_0020_0040_0040, 4'h0);
		chk_rd("fres1", `MFB_ADR_FRES1, 32'h8000); // First pair
		chk_rd("fres2", `MFB_ADR_FRES2, 32'h6000); // Second pair
		chk_rd("fres3", `MFB_ADR_FRES3, 32'h3000); // Third pair
		`CHK("out", 32'h1C, out_data_o) // Mapped onto limits
		chk_rd("result", `MFB_ADR_RESULT, 32'h0000_001C); // Result register
		`CHK("lims", 64'h0000_000A_0000_006E, {out_min_o, out_max_o}) // Limits for consumers
		wb_wr(8'h40, 32'h0);
		repeat (26) @(posedge clk_i);
		chk_rd("skip", `MFB_ADR_FPCT, 32'h6000); // Last input unused
		`CHK("out", 32'h2F, out_data_o) // Earlier result mapped
	endtask
	task automatic t_weight();
		wb_wr(8'h30, 32'h0);
		wb_wr(`MFB_ADR_OPS, 32'h0000_0999);
		wb_wr(8'h1C, 32'h0000_2000);
		set_vals(64'h0000_0000_0080_0200, 4'h2);
		chk_rd("err", `MFB_ADR_FPCT, 32'h8000); // Half weight, error zero
		chk_rd("stat", `MFB_ADR_STAT, 32'h0000_0102); // Error seen, output valid
		wb_wr(8'h1C, 32'h0000_C000);
		set_vals(64'h0000_0000_0080_0100, 4'h0);
		chk_rd("neg", `MFB_ADR_FPCT, 32'hFFFF_8000); // Negative weight
		`CHK("out", 32'h0A, out_data_o) // Clamped to minimum
	endtask
	task automatic t_self();
		wb_wr(8'h1C, 32'h0000_4000);
		set_in(4'h3, 32'h12, 32'h4000);
		wb_wr(`MFB_ADR_OPS, 32'h0000_0906);
		set_vals(64'h0000_0000_0080_0000, 4'h0);
		chk_rd("self", `MFB_ADR_FRES2, 32'h10000); // Function one fed back
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		test_done();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_ops();
		t_edges();
		t_chain();
		t_weight();
		t_self();
		test_done();
	end
endmodule
